// >>> inc/sdsm_defines.svh
// Constants for the axis power state machine: object indices, fields, codes.
// Assumes inclusion by bare name from the core module, the master model and the testbench.
`ifndef SDSM_DEFINES_SVH
`define SDSM_DEFINES_SVH
// Object indices
`define SDSM_IDX_CMD      16'h6040
`define SDSM_IDX_STAT     16'h6041
`define SDSM_IDX_QHALT    16'h605A
`define SDSM_IDX_SHUT     16'h605B
`define SDSM_IDX_DISRUN   16'h605C
`define SDSM_IDX_FRESP    16'h605E
`define SDSM_IDX_MSEL     16'h6060
`define SDSM_IDX_MDISP    16'h6061
`define SDSM_IDX_SUPP     16'h6502
// Command word fields
`define SDSM_CMD_CLR      7
`define SDSM_CMD_RUN      3
`define SDSM_CMD_HALT     2
`define SDSM_CMD_PWR      1
`define SDSM_CMD_NRG      0
// State word fields
`define SDSM_ST_LOCK      6
`define SDSM_ST_HALT      5
`define SDSM_ST_MAINS     4
`define SDSM_ST_FAULT     3
`define SDSM_ST_RUN       2
`define SDSM_ST_NRG       1
`define SDSM_ST_ARM       0
// Mode codes
`define SDSM_MODE_NONE    8'h00
`define SDSM_MODE_PPOS    8'h01
`define SDSM_MODE_PSPD    8'h03
`define SDSM_MODE_HOME    8'h06
`define SDSM_MODE_CPOS    8'h08
`define SDSM_MODE_CSPD    8'h09
`define SDSM_MODE_CTRQ    8'h0A
`define SDSM_SUPP_VALUE   32'h0000_03A5
// Reset values
`define SDSM_OPT_RESET    16'h0000
`endif

// >>> inc/sdsm_pkg.sv
// Types for the axis power state machine.
// Assumes the defines header is on the include path.
package sdsm_pkg;
    // Eight power states, state word bits 6,3,2,1,0
    typedef enum logic [4:0] {
        SDSM_NOT_READY = 5'b00000,
        SDSM_DISABLED  = 5'b10000,
        SDSM_READY     = 5'b00001,
        SDSM_SW_ON     = 5'b00011,
        SDSM_ENABLED   = 5'b00111,
        SDSM_QSTOP     = 5'b00101,
        SDSM_REACT     = 5'b01111,
        SDSM_FAULT     = 5'b01000
    } sdsm_state_type;
    // Stop action presented to the control loops
    typedef enum logic [1:0] {
        SDSM_STOP_NONE  = 2'b00,
        SDSM_STOP_DECEL = 2'b01,
        SDSM_STOP_BRAKE = 2'b10,
        SDSM_STOP_FREE  = 2'b11
    } sdsm_stop_type;
endpackage : sdsm_pkg

// >>> core/sdsm_core.sv
// Axis power state machine: command decode, state word, stop selection, modes.
// Assumes objects arrive as index/write strobes from the network stack on clock.
`timescale 1ns/1ps
`default_nettype none
`include "sdsm_defines.svh"
module sdsm_core (
    input  wire logic                  clock,
    input  wire logic                  rst_n,
    input  wire logic                  clk_en,
    input  wire logic                  init_done,     // Initialisation finished
    input  wire logic                  main_power_in, // Pin, main circuit power
    input  wire logic                  error_in,      // Error detected, level
    input  wire logic                  major_fault,   // Error is major
    input  wire logic                  stop_done,     // Motor stop completed
    input  wire logic                  obj_wr,        // Object write strobe
    input  wire logic [15:0]           obj_index,     // Object index
    input  wire logic [31:0]           obj_wdata,     // Write data
    input  wire logic [15:0]           disable_stop_param,
    input  wire logic [15:0]           fault_stop_param,
    input  wire logic [15:0]           shutdown_stop_param,
    input  wire logic [7:0]            active_mode,   // Mode loops really run
    output logic [31:0]                obj_rdata,     // Read data for obj_index
    output logic                       obj_ack,       // Write accepted
    output logic [15:0]                state_word,
    output sdsm_pkg::sdsm_state_type   axis_power_state,
    output logic                       servo_enable,
    output logic                       error_clear,   // One-cycle error reset
    output sdsm_pkg::sdsm_stop_type    stop_req,
    output logic [3:0]                 stop_digit,    // Parameter digit chosen
    output logic [7:0]                 mode_request
);
    import sdsm_pkg::*;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic mp_s1_r, main_power_flag;          // Main power two-stage sync
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mp_s1_r         <= 1'b0;
            main_power_flag <= 1'b0;
        end else if (clk_en) begin
            mp_s1_r         <= main_power_in;
            main_power_flag <= mp_s1_r;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [15:0]    cmd_r, qhalt_r, shut_r, disrun_r, fresp_r; // Objects
    logic [7:0]     msel_r;                  // Mode select
    logic           clr_prev_r;              // Previous clear bit
    sdsm_state_type state_r, state_nxt;      // Power state
    sdsm_stop_type  stop_r, stop_nxt;        // Active stop action
    logic [3:0]     digit_r, digit_nxt;      // Selected parameter digit
    logic           clear_r;                 // Error reset pulse
    logic [15:0]    word_r;                  // State word

    // Parameter digit n (1 = lowest) of a 4-digit hex parameter
    function automatic logic [3:0] digit_of(input logic [15:0] p, input int n);
        digit_of = p[(n-1)*4 +: 4];
    endfunction : digit_of

    // Option code to stop type; zero means brake per parameter
    function automatic sdsm_stop_type opt_stop(input logic [15:0] o);
        opt_stop = (o == 16'h0000) ? SDSM_STOP_BRAKE : SDSM_STOP_DECEL;
    endfunction : opt_stop

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    wire cmd_write  = obj_wr && (obj_index == `SDSM_IDX_CMD);
    wire b_run  = cmd_r[`SDSM_CMD_RUN];
    wire b_halt = cmd_r[`SDSM_CMD_HALT];     // Halt now, active low
    wire b_pwr  = cmd_r[`SDSM_CMD_PWR];
    wire b_nrg  = cmd_r[`SDSM_CMD_NRG];
    wire b_clr  = cmd_r[`SDSM_CMD_CLR];
    wire c_shutdown = b_halt && b_pwr && !b_nrg;
    wire c_switchon = b_halt && b_pwr && b_nrg && !b_run;
    wire c_enable   = b_halt && b_pwr && b_nrg && b_run;
    wire c_qstop    = !b_halt && b_pwr && b_nrg && b_run;
    wire c_nopower  = !b_pwr;
    wire clr_edge   = b_clr && !clr_prev_r;
    wire powered    = (state_r == SDSM_SW_ON) || (state_r == SDSM_ENABLED)
                      || (state_r == SDSM_QSTOP);
    // Parameter writes refused only while initialising
    wire wr_ok      = (state_r != SDSM_NOT_READY);

    // ----------------------------------------------------------------
    // Next state and stop selection
    // ----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;                 // Unmatched: hold
        stop_nxt  = stop_r;
        digit_nxt = digit_r;
        unique case (state_r)
            SDSM_NOT_READY: begin
                if (init_done) state_nxt = SDSM_DISABLED;
            end
            SDSM_DISABLED: begin
                if (c_shutdown) state_nxt = SDSM_READY;
            end
            SDSM_READY: begin
                if (c_nopower) state_nxt = SDSM_DISABLED;
                else if ((c_switchon || c_enable) && main_power_flag)
                    state_nxt = SDSM_SW_ON;
            end
            SDSM_SW_ON: begin
                if (c_nopower) state_nxt = SDSM_DISABLED;
                else if (c_shutdown) state_nxt = SDSM_READY;
                else if (c_enable) state_nxt = SDSM_ENABLED;
            end
            SDSM_ENABLED: begin
                if (c_nopower || c_shutdown) begin
                    state_nxt = c_nopower ? SDSM_DISABLED : SDSM_READY;
                    stop_nxt  = opt_stop(shut_r);
                    digit_nxt = (opt_stop(shut_r) == SDSM_STOP_BRAKE) ?
                                digit_of(shutdown_stop_param, 1) :
                                digit_of(shutdown_stop_param, 2);
                end else if (c_switchon) begin
                    state_nxt = SDSM_SW_ON;
                    stop_nxt  = opt_stop(disrun_r);
                    digit_nxt = (opt_stop(disrun_r) == SDSM_STOP_BRAKE) ?
                                digit_of(disable_stop_param, 1) :
                                digit_of(disable_stop_param, 2);
                end else if (c_qstop) begin
                    state_nxt = SDSM_QSTOP;
                    stop_nxt  = (qhalt_r == 16'h0000) ? SDSM_STOP_FREE :
                                SDSM_STOP_DECEL;
                    digit_nxt = qhalt_r[3:0];
                end
            end
            SDSM_QSTOP: begin
                if (c_nopower) state_nxt = SDSM_DISABLED;
            end
            SDSM_REACT: begin
                stop_nxt  = opt_stop(fresp_r);
                digit_nxt = major_fault ? digit_of(fault_stop_param, 2) :
                            digit_of(fault_stop_param, 4);
                if (stop_done) begin
                    state_nxt = SDSM_FAULT;
                    stop_nxt  = SDSM_STOP_BRAKE;
                    digit_nxt = digit_of(fault_stop_param, 1);
                end
            end
            SDSM_FAULT: begin
                if (clr_edge) begin
                    state_nxt = SDSM_DISABLED;
                    stop_nxt  = SDSM_STOP_NONE;
                end
            end
            default: state_nxt = SDSM_NOT_READY;
        endcase
        // Error overrides commands in all states but not-ready, reaction and fault
        if (error_in && powered) begin
            state_nxt = SDSM_REACT;
            stop_nxt  = opt_stop(fresp_r);
            digit_nxt = major_fault ? digit_of(fault_stop_param, 2) :
                        digit_of(fault_stop_param, 4);
        end else if (error_in && (state_r == SDSM_DISABLED ||
                                  state_r == SDSM_READY)) begin
            state_nxt = SDSM_FAULT;
        end
        // Stop clears once motion is back under enable
        if (state_nxt == SDSM_ENABLED) stop_nxt = SDSM_STOP_NONE;
    end

    // ----------------------------------------------------------------
    // Object writes
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmd_r    <= 16'h0000;
            qhalt_r  <= `SDSM_OPT_RESET;
            shut_r   <= `SDSM_OPT_RESET;
            disrun_r <= `SDSM_OPT_RESET;
            fresp_r  <= `SDSM_OPT_RESET;
            msel_r   <= `SDSM_MODE_NONE;
        end else if (clk_en && obj_wr) begin
            if (obj_index == `SDSM_IDX_CMD) cmd_r <= obj_wdata[15:0];
            if (wr_ok) begin
                if (obj_index == `SDSM_IDX_QHALT)  qhalt_r  <= obj_wdata[15:0];
                if (obj_index == `SDSM_IDX_SHUT)   shut_r   <= obj_wdata[15:0];
                if (obj_index == `SDSM_IDX_DISRUN) disrun_r <= obj_wdata[15:0];
                if (obj_index == `SDSM_IDX_FRESP)  fresp_r  <= obj_wdata[15:0];
                if (obj_index == `SDSM_IDX_MSEL)   msel_r   <= obj_wdata[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // State registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r    <= SDSM_NOT_READY;
            stop_r     <= SDSM_STOP_NONE;
            digit_r    <= 4'h0;
            clr_prev_r <= 1'b0;
            clear_r    <= 1'b0;
        end else if (clk_en) begin
            state_r    <= state_nxt;
            stop_r     <= stop_nxt;
            digit_r    <= digit_nxt;
            clr_prev_r <= b_clr;
            clear_r    <= (state_r == SDSM_FAULT) && clr_edge;
        end
    end

    // ----------------------------------------------------------------
    // State word
    // ----------------------------------------------------------------
    logic [15:0] word_nxt;
    assign word_nxt = {9'h000, state_nxt[4],
                       (state_nxt == SDSM_READY) || (state_nxt == SDSM_SW_ON) ||
                       (state_nxt == SDSM_ENABLED),
                       main_power_flag && (state_nxt != SDSM_NOT_READY), // Zero while initialising
                       state_nxt[3:0]};
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) word_r <= 16'h0000;
        else if (clk_en) word_r <= word_nxt;
    end

    // ----------------------------------------------------------------
    // Outputs and read mux
    // ----------------------------------------------------------------
    wire running = (state_r == SDSM_ENABLED);
    assign state_word       = word_r;
    assign axis_power_state = state_r;
    assign servo_enable     = running;
    assign error_clear      = clear_r;
    assign stop_req         = stop_r;
    assign stop_digit       = digit_r;
    assign mode_request     = msel_r;
    assign obj_ack          = obj_wr && (wr_ok || cmd_write);
    // Mode display shows running mode only with servo on
    wire [7:0] mode_shown = running ? active_mode : `SDSM_MODE_NONE;
    always_comb begin
        unique case (obj_index)
            `SDSM_IDX_CMD:    obj_rdata = {16'h0000, cmd_r};
            `SDSM_IDX_STAT:   obj_rdata = {16'h0000, word_r};
            `SDSM_IDX_QHALT:  obj_rdata = {16'h0000, qhalt_r};
            `SDSM_IDX_SHUT:   obj_rdata = {16'h0000, shut_r};
            `SDSM_IDX_DISRUN: obj_rdata = {16'h0000, disrun_r};
            `SDSM_IDX_FRESP:  obj_rdata = {16'h0000, fresp_r};
            `SDSM_IDX_MSEL:   obj_rdata = {24'h000000, msel_r};
            `SDSM_IDX_MDISP:  obj_rdata = {24'h000000, mode_shown};
            `SDSM_IDX_SUPP:   obj_rdata = `SDSM_SUPP_VALUE;
            default:          obj_rdata = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_in_fault_clr; state_r == SDSM_FAULT && clr_edge && !error_in && clk_en;
    endsequence
    a_fault_clear_exit: assert property (@(posedge clock) disable iff (!rst_n)
        s_in_fault_clr |=> state_r == SDSM_DISABLED && clear_r)
        else $error("fault clear did not leave fault");
    a_enable_needs_power: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(state_r == SDSM_SW_ON) && $past(state_r) == SDSM_READY
        |-> $past(main_power_flag))
        else $error("switched on without main power");
    a_error_reacts: assert property (@(posedge clock) disable iff (!rst_n)
        error_in && powered && clk_en |=> state_r == SDSM_REACT)
        else $error("error did not force fault reaction");
    a_react_to_fault: assert property (@(posedge clock) disable iff (!rst_n)
        state_r == SDSM_REACT && stop_done && !error_in && clk_en
        |=> state_r == SDSM_FAULT)
        else $error("reaction did not end in fault");
    a_word_lock_bit: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en |=> state_word[`SDSM_ST_LOCK] == $past(state_nxt == SDSM_DISABLED))
        else $error("lockout bit wrong");
    a_quick_free_run: assert property (@(posedge clock) disable iff (!rst_n)
        state_r == SDSM_ENABLED && c_qstop && qhalt_r == 16'h0000 && !error_in
        && clk_en |=> stop_req == SDSM_STOP_FREE)
        else $error("quick halt none not free-run");
    a_shutdown_brake: assert property (@(posedge clock) disable iff (!rst_n)
        state_r == SDSM_ENABLED && c_shutdown && shut_r == 16'h0000 && !error_in
        && clk_en |=> stop_req == SDSM_STOP_BRAKE
        && stop_digit == $past(shutdown_stop_param[3:0]))
        else $error("shutdown brake digit wrong");
    a_disable_run_stop: assert property (@(posedge clock) disable iff (!rst_n)
        state_r == SDSM_ENABLED && c_switchon && disrun_r != 16'h0000 && !error_in
        && clk_en |=> stop_req == SDSM_STOP_DECEL
        && stop_digit == $past(disable_stop_param[7:4]))
        else $error("disable run decel digit wrong");
    a_no_clear_outside: assert property (@(posedge clock) disable iff (!rst_n)
        state_r != SDSM_FAULT && clk_en |=> !clear_r)
        else $error("clear pulse outside fault");
endmodule : sdsm_core
`default_nettype wire

// >>> sim/sdsm_master.sv
// Network master model: object writes and reads on the object port.
// Assumes the core answers writes on obj_ack in the same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "sdsm_defines.svh"
module sdsm_master (
    input  wire logic        clock,
    input  wire logic        obj_ack,
    input  wire logic [31:0] obj_rdata,
    output logic             obj_wr,
    output logic [15:0]      obj_index,
    output logic [31:0]      obj_wdata
);
    logic [7:0] last_cmd; // Last command word sent
    initial begin
        obj_wr    = 1'b0;
        obj_index = 16'hFFFF;
        obj_wdata = 32'h0;
        last_cmd  = 8'h00;
    end
    // One write strobe, held to its sampling edge, lines scrambled after
    task automatic wr(input logic [15:0] idx, input logic [31:0] d, output logic ack);
        @(posedge clock);
        obj_wr    <= 1'b1;
        obj_index <= idx;
        obj_wdata <= d;
        @(posedge clock);
        ack = obj_ack;
        obj_wr    <= 1'b0;
        obj_index <= ~idx;
        obj_wdata <= ~d;
    endtask : wr
    // Combinational read of one object
    task automatic rd(input logic [15:0] idx, output logic [31:0] d);
        @(posedge clock);
        obj_index <= idx;
        @(posedge clock);
        d = obj_rdata;
        obj_index <= ~idx;
    endtask : rd
    // Command word; clear bit dropped first so a new clear rises
    task automatic command(input logic [7:0] c);
        logic a;
        if (last_cmd[7] && c[7]) begin
            wr(`SDSM_IDX_CMD, {24'h0, c & 8'h7F}, a);
        end
        wr(`SDSM_IDX_CMD, {24'h0, c}, a);
        last_cmd = c;
    endtask : command
endmodule : sdsm_master
`default_nettype wire

// >>> sim/tb_servo_drive_state_machine.sv
// Testbench: state model with integers compared with the core at every step.
// Assumes the core, package and the master model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "sdsm_defines.svh"
module tb_servo_drive_state_machine;
    import sdsm_pkg::*;
    logic clock = 0, rst_n = 0, init_done = 0, main_power_in = 1, error_in = 0, clk_en = 1;
    logic major_fault = 0, stop_done = 0, obj_wr, obj_ack, servo_enable, error_clear;
    logic [15:0] obj_index, state_word, dis_p = 0, flt_p = 0, shut_p = 0, dis_opt;
    logic [31:0] obj_wdata, obj_rdata, rd;
    logic [7:0]  active_mode = 0, mode_request;
    logic [3:0]  stop_digit;
    logic        ack;
    sdsm_state_type st;
    sdsm_stop_type  stp;
    int mismatches = 0, checked = 0, clears = 0, exp = 0;
    logic [7:0] modes [6] = '{`SDSM_MODE_CPOS, `SDSM_MODE_CSPD, `SDSM_MODE_CTRQ,
                              `SDSM_MODE_PPOS, `SDSM_MODE_PSPD, `SDSM_MODE_HOME};
    always #5 clock = ~clock; // 100 MHz
    always @(posedge clock) if (error_clear === 1'b1) clears++; // Clear pulses seen
    sdsm_core sdsm_core_inst (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
        .init_done(init_done), .main_power_in(main_power_in), .error_in(error_in),
        .major_fault(major_fault), .stop_done(stop_done), .obj_wr(obj_wr),
        .obj_index(obj_index), .obj_wdata(obj_wdata), .disable_stop_param(dis_p),
        .fault_stop_param(flt_p), .shutdown_stop_param(shut_p),
        .active_mode(active_mode), .obj_rdata(obj_rdata), .obj_ack(obj_ack),
        .state_word(state_word), .axis_power_state(st), .servo_enable(servo_enable),
        .error_clear(error_clear), .stop_req(stp), .stop_digit(stop_digit),
        .mode_request(mode_request));
    sdsm_master sdsm_master_inst (.clock(clock), .obj_ack(obj_ack),
        .obj_rdata(obj_rdata), .obj_wr(obj_wr), .obj_index(obj_index),
        .obj_wdata(obj_wdata));
    // Reference next state from the command bits
    function automatic int nxt(int s, logic [7:0] c, logic p);
        if (s == 8) return c[7] ? 16 : 8;
        if (!c[1]) return 16;
        if (c[2:0] == 3'b110 && s inside {16, 1, 3, 7}) return 1;
        if (c[3:0] == 4'hF && s inside {1, 3} && p) return 7;
        if (c[3:0] == 4'h7 && s inside {1, 7} && p) return 3;
        if (c[3:0] == 4'hB && s == 7) return 5;
        return s;
    endfunction : nxt
    // Value comparison
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // State comparison after a bounded wait
    task automatic settle(input int s);
        int n;
        logic h;
        n = 0;
        h = (s inside {1, 3, 7});
        while (st !== s[4:0] && n < 20) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk("state", s, st);
        chk("word", {s[4], h, main_power_in && (s != 0), s[3:0]} & (h ? 7'h7F : 7'h5F),
            state_word & (h ? 16'h007F : 16'h005F));
        chk("servo on", s == 7, servo_enable);
    endtask : settle
    // Command then model step
    task automatic cmd(input logic [7:0] c);
        sdsm_master_inst.command(c);
        exp = nxt(exp, c, main_power_in);
        settle(exp);
    endtask : cmd
    task automatic give_verdict();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict
    initial begin
        #300us;
        mismatches++;
        give_verdict();
    end
    // Main sequence
    initial begin
        void'($urandom(32'hEE59542F));
        dis_opt = 16'($urandom_range(4, 1));
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        dis_p <= 16'($urandom);
        flt_p <= 16'($urandom);
        shut_p <= 16'($urandom);
        settle(0);
        sdsm_master_inst.wr(`SDSM_IDX_SHUT, 32'h0, ack);
        chk("refused ack", 0, ack);
        init_done <= 1'b1;
        exp = 16;
        settle(exp);
        sdsm_master_inst.wr(`SDSM_IDX_SHUT, 32'h0, ack);
        sdsm_master_inst.wr(`SDSM_IDX_QHALT, 32'h0, ack);
        sdsm_master_inst.wr(`SDSM_IDX_FRESP, 32'h1, ack);
        sdsm_master_inst.wr(`SDSM_IDX_DISRUN, {16'h0, dis_opt}, ack);
        chk("write ack", 1, ack);
        sdsm_master_inst.rd(`SDSM_IDX_DISRUN, rd);
        chk("option", dis_opt, rd[15:0]);
        cmd(8'h0F);
        cmd(8'h06);
        cmd(8'h0F);
        cmd(8'h06);
        chk("shut stop", {2'd2, shut_p[3:0]}, {stp, stop_digit});
        cmd(8'h0F);
        cmd(8'h07);
        chk("dis stop", {2'd1, dis_p[7:4]}, {stp, stop_digit});
        cmd(8'h0F);
        cmd(8'h0B);
        chk("quick stop", 2'd3, stp);
        cmd(8'h00);
        cmd(8'h86);
        @(posedge clock);
        #1;
        chk("clears", 0, clears);
        @(posedge clock);
        main_power_in <= 1'b0;
        repeat (4) @(posedge clock);
        cmd(8'h07);
        @(posedge clock);
        main_power_in <= 1'b1;
        repeat (4) @(posedge clock);
        for (int mj = 0; mj < 2; mj++) begin
            cmd(8'h0F);
            @(posedge clock);
            major_fault <= mj[0];
            error_in <= 1'b1;
            exp = 15;
            settle(exp);
            chk("react digit", mj ? flt_p[7:4] : flt_p[15:12], stop_digit);
            @(posedge clock);
            stop_done <= 1'b1;
            exp = 8;
            settle(exp);
            chk("fault digit", flt_p[3:0], stop_digit);
            @(posedge clock);
            stop_done <= 1'b0;
            error_in <= 1'b0;
            cmd(8'h80);
            @(posedge clock);
            #1;
            chk("clears", mj + 1, clears);
            cmd(8'h06);
        end
        cmd(8'h0F);
        foreach (modes[i]) begin
            @(posedge clock);
            active_mode <= modes[i];
            sdsm_master_inst.wr(`SDSM_IDX_MSEL, {24'h0, modes[i]}, ack);
            sdsm_master_inst.rd(`SDSM_IDX_MDISP, rd);
            chk("mode request", modes[i], mode_request);
            chk("mode display", modes[i], rd);
        end
        // Frozen core ignores a command written while enable is low
        @(posedge clock);
        clk_en <= 1'b0;
        sdsm_master_inst.command(8'h06);
        repeat (3) @(posedge clock);
        #1;
        chk("frozen state", 7, st);
        @(posedge clock);
        clk_en <= 1'b1;
        cmd(8'h06);
        sdsm_master_inst.rd(`SDSM_IDX_MDISP, rd);
        chk("mode display off", 0, rd);
        sdsm_master_inst.rd(`SDSM_IDX_SUPP, rd);
        chk("supported", `SDSM_SUPP_VALUE, rd);
        sdsm_master_inst.rd(16'h6000, rd);
        chk("unmapped", 0, rd);
        give_verdict();
    end
endmodule : tb_servo_drive_state_machine
`default_nettype wire
